/* rtl/dmb_pkg.sv */
package dmb_pkg;
    // Data and array shape
    localparam int DQ_W   = 8;
    localparam int COL_W  = 6;
    localparam int BEAT_W = 3;
    localparam int LAT_W  = 6;

    // Mode register zero fields
    localparam int MR0_BL_LO   = 0;
    localparam int MR0_BL_HI   = 1;
    localparam int MR0_CL_EXT  = 2;
    localparam int MR0_BTYPE   = 3;
    localparam int MR0_CL_LO   = 4;
    localparam int MR0_CL_HI   = 6;
    localparam int MR0_TEST    = 7;
    localparam int MR0_DLL_RST = 8;
    localparam int MR0_WR_LO   = 9;
    localparam int MR0_WR_HI   = 11;
    localparam int MR0_PPD     = 12;

    // Mode register one fields
    localparam int MR1_DLL_DIS = 0;
    localparam int MR1_DRV_LO  = 1;
    localparam int MR1_RTT_B0  = 2;
    localparam int MR1_AL_LO   = 3;
    localparam int MR1_AL_HI   = 4;
    localparam int MR1_DRV_HI  = 5;
    localparam int MR1_RTT_B1  = 6;
    localparam int MR1_RTT_B2  = 9;

    localparam logic [15:0] MR_RESET = 16'h0000;

    // Burst length field codes
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF  = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;

    // Added latency codes
    localparam logic [1:0] AL_CL1 = 2'h1;
    localparam logic [1:0] AL_CL2 = 2'h2;

    // Bank select patterns for the two mode registers
    localparam logic [2:0] BA_MR0 = 3'h0;
    localparam logic [2:0] BA_MR1 = 3'h1;

    // Latency and burst constants
    localparam logic [LAT_W-1:0]  CL_BASE     = 6'h04;
    localparam logic [LAT_W-1:0]  LAT_ONE     = 6'h01;
    localparam logic [LAT_W-1:0]  LAT_TWO     = 6'h02;
    localparam logic [BEAT_W-1:0] BEAT_LAST   = 3'h7;
    localparam logic [BEAT_W-1:0] CHOP_LAST   = 3'h3;
    localparam int                CHOP_EARLY_CK = 2;

    // Timing
    localparam int CORE_MHZ     = 50;
    localparam int DLL_RST_NS   = 100;
    localparam int DLL_RST_CYC  = (DLL_RST_NS * CORE_MHZ + 999) / 1000;

    // Write recovery code to cycles
    function automatic logic [LAT_W-1:0] wr_cycles(input logic [2:0] code);
        logic [LAT_W-1:0] r;
        r = 6'h10;
        case (code)
            3'h1: r = 6'h05;
            3'h2: r = 6'h06;
            3'h3: r = 6'h07;
            3'h4: r = 6'h08;
            3'h5: r = 6'h0a;
            3'h6: r = 6'h0c;
            3'h7: r = 6'h0e;
            default: r = 6'h10;
        endcase
        return r;
    endfunction : wr_cycles

    typedef enum logic [2:0] {ST_IDLE, ST_RD_WAIT, ST_RD_BURST, ST_WR_WAIT, ST_WR_BURST} dmb_state_e;
endpackage : dmb_pkg

/* rtl/dmb_mem_if.sv */
`timescale 1ns/1ps
interface dmb_mem_if #(
    parameter int W  = 8,
    parameter int AW = 6
);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [W-1:0]  wr_data;
    logic [AW-1:0] rd_addr;
    logic [W-1:0]  rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : dmb_mem_if

/* rtl/dmb_burst_mem.sv */
`timescale 1ns/1ps
module dmb_burst_mem #(
    parameter int W  = 8,
    parameter int AW = 6
) (
    // Clock
    input  wire logic core_clk_i,
    // Array port
    dmb_mem_if.mem    port
);
    logic [W-1:0] mem_q [2**AW];
    logic [W-1:0] rd_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (port.wr_en)
        begin
            mem_q[port.wr_addr] <= port.wr_data;
        end
    end

    // Registered read keeps the data path timing fixed
    always_ff @(posedge core_clk_i)
    begin
        rd_reg <= mem_q[port.rd_addr];
    end

    assign port.rd_data = rd_reg;
endmodule : dmb_burst_mem

/* rtl/dmb_mode_burst.sv */
`timescale 1ns/1ps
module dmb_mode_burst
    import dmb_pkg::*;
#(
    parameter logic [LAT_W-1:0] CWL_CYC    = 6'h05,
    parameter logic [LAT_W-1:0] PRECHG_CYC = 6'h06
) (
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              sys_rst_i,
    // Command pins
    input  wire logic              ck_i,
    input  wire logic              cke_i,
    input  wire logic              chip_sel_n_i,
    input  wire logic              row_strobe_n_i,
    input  wire logic              column_strobe_n_i,
    input  wire logic              write_en_n_i,
    input  wire logic [2:0]        bank_sel_i,
    input  wire logic [15:0]       addr_i,
    input  wire logic              die_termination_i,
    input  wire logic [1:0]        wr_term_code_i,
    // Data pins
    input  wire logic [DQ_W-1:0]   dq_i,
    output logic      [DQ_W-1:0]   dq_o,
    output logic                   dq_oe_n_o,
    output logic                   dqs_o,
    output logic                   dqs_oe_n_o,
    // Status
    output logic                   dll_active_o,
    output logic                   dll_needed_o,
    output logic                   fast_exit_o,
    output logic                   test_mode_o,
    output logic [1:0]             drive_imp_o,
    output logic [2:0]             rtt_nom_o,
    output logic                   term_on_o,
    output logic [LAT_W-1:0]       read_latency_o,
    output logic [LAT_W-1:0]       autoclose_dly_o,
    output logic                   wr_recov_start_o
);
    localparam int CMD_W = 25;

    // Pin synchronisers
    logic [CMD_W-1:0] cmd_s1, cmd_s2;
    logic [DQ_W-1:0]  dq_s1, dq_s2;
    logic [1:0]       wt_s1, wt_s2;
    logic             ck_s2, ck_d;

    always_ff @(posedge core_clk_i)
    begin
        cmd_s1 <= {ck_i, cke_i, chip_sel_n_i, row_strobe_n_i, column_strobe_n_i,
                   write_en_n_i, bank_sel_i, addr_i};
        cmd_s2 <= cmd_s1;
        dq_s1  <= dq_i;
        dq_s2  <= dq_s1;
        wt_s1  <= wr_term_code_i;
        wt_s2  <= wt_s1;
        ck_d   <= ck_s2;
    end

    always_comb
    begin
        ck_s2 = cmd_s2[CMD_W-1];
    end

    logic        cke, cs_n, ras_n, cas_n, we_n;
    logic [2:0]  ba;
    logic [15:0] addr;
    logic        odt_s1, odt_s2;
    logic        ck_rise, ck_edge;

    always_ff @(posedge core_clk_i)
    begin
        odt_s1 <= die_termination_i;
        odt_s2 <= odt_s1;
    end

    assign {cke, cs_n, ras_n, cas_n, we_n, ba, addr} = cmd_s2[CMD_W-2:0];
    assign ck_rise = ck_s2 & ~ck_d;
    assign ck_edge = ck_s2 ^ ck_d;

    logic cke_prev_reg;
    logic mrs_cmd, rd_cmd, wr_cmd, sr_entry;

    assign mrs_cmd  = ck_rise & cke & ~cs_n & ~ras_n & ~cas_n & ~we_n;
    assign rd_cmd   = ck_rise & cke & ~cs_n & ras_n & ~cas_n & we_n;
    assign wr_cmd   = ck_rise & cke & ~cs_n & ras_n & ~cas_n & ~we_n;
    assign sr_entry = ck_rise & cke_prev_reg & ~cke & ~cs_n & ~ras_n & ~cas_n & we_n;

    // Mode registers
    logic [15:0]            mr0_reg, mr1_reg;
    logic [LAT_W-1:0]       dll_rst_cnt_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            mr0_reg         <= MR_RESET;
            dll_rst_cnt_reg <= '0;
        end
        else if (mrs_cmd && ba == BA_MR0)
        begin
            mr0_reg         <= addr;
            dll_rst_cnt_reg <= addr[MR0_DLL_RST] ? LAT_W'(DLL_RST_CYC) : '0;
        end
        else if (dll_rst_cnt_reg == LAT_ONE)
        begin
            mr0_reg[MR0_DLL_RST] <= 1'b0;
            dll_rst_cnt_reg      <= '0;
        end
        else if (dll_rst_cnt_reg != '0)
        begin
            dll_rst_cnt_reg <= dll_rst_cnt_reg - LAT_ONE;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            mr1_reg <= MR_RESET;
        end
        else if (mrs_cmd && ba == BA_MR1)
        begin
            mr1_reg <= addr;
        end
    end

    // Latency decode
    logic [LAT_W-1:0] cl_cyc, al_cyc, rl_cyc, wl_cyc;
    logic [1:0]       al_code;

    always_comb
    begin
        cl_cyc  = CL_BASE + LAT_W'({mr0_reg[MR0_CL_EXT], mr0_reg[MR0_CL_HI:MR0_CL_LO]});
        al_code = mr1_reg[MR1_AL_HI:MR1_AL_LO];
        al_cyc  = '0;
        if (al_code == AL_CL1)
        begin
            al_cyc = cl_cyc - LAT_ONE;
        end
        else if (al_code == AL_CL2)
        begin
            al_cyc = cl_cyc - LAT_TWO;
        end
        rl_cyc = al_cyc + cl_cyc;
        wl_cyc = al_cyc + CWL_CYC;
    end

    // Burst order
    function automatic logic [2:0] beat_col(input logic [2:0] s, input logic [2:0] i,
                                            input logic il);
        logic [2:0] r;
        r = il ? (s ^ i) : {s[2] ^ i[2], 2'(s[1:0] + i[1:0])};
        return r;
    endfunction : beat_col

    // Power state
    logic sr_reg, pd_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            cke_prev_reg <= 1'b0;
            sr_reg       <= 1'b0;
            pd_reg       <= 1'b0;
        end
        else if (ck_rise)
        begin
            cke_prev_reg <= cke;
            if (sr_entry)
            begin
                sr_reg <= 1'b1;
            end
            else if (cke)
            begin
                sr_reg <= 1'b0;
                pd_reg <= 1'b0;
            end
            else if (cke_prev_reg)
            begin
                pd_reg <= 1'b1;
            end
        end
    end

    // Burst engine
    dmb_state_e          state_reg;
    logic [LAT_W-1:0]    lat_reg;
    logic [BEAT_W-1:0]   beat_reg;
    logic [COL_W-1:0]    col_reg;
    logic                chop_reg, il_reg, early_reg;
    logic                chop_now;

    // Chop choice: fixed code always chops; on-the-fly code has pin low select chop
    always_comb
    begin
        chop_now = 1'b0;
        if (mr0_reg[MR0_BL_HI:MR0_BL_LO] == BL_FIX4)
        begin
            chop_now = 1'b1;
        end
        else if (mr0_reg[MR0_BL_HI:MR0_BL_LO] == BL_OTF)
        begin
            chop_now = ~addr[12];
        end
    end

    // One burst at a time; read and write commands during a burst are dropped
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            state_reg <= ST_IDLE;
            lat_reg   <= '0;
            beat_reg  <= '0;
            col_reg   <= '0;
            chop_reg  <= 1'b0;
            il_reg    <= 1'b0;
            early_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (rd_cmd || wr_cmd)
                    begin
                        col_reg   <= addr[COL_W-1:0];
                        chop_reg  <= chop_now;
                        il_reg    <= mr0_reg[MR0_BTYPE];
                        early_reg <= mr0_reg[MR0_BL_HI:MR0_BL_LO] == BL_FIX4;
                        lat_reg   <= rd_cmd ? rl_cyc : wl_cyc;
                        state_reg <= rd_cmd ? ST_RD_WAIT : ST_WR_WAIT;
                    end
                end
                ST_RD_WAIT, ST_WR_WAIT:
                begin
                    if (ck_rise)
                    begin
                        if (lat_reg <= LAT_ONE)
                        begin
                            beat_reg  <= '0;
                            state_reg <= (state_reg == ST_RD_WAIT) ? ST_RD_BURST : ST_WR_BURST;
                        end
                        else
                        begin
                            lat_reg <= lat_reg - LAT_ONE;
                        end
                    end
                end
                ST_RD_BURST, ST_WR_BURST:
                begin
                    if (ck_edge)
                    begin
                        beat_reg <= beat_reg + 3'h1;
                        if (beat_reg == BEAT_LAST)
                        begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Array access
    dmb_mem_if #(.W(DQ_W), .AW(COL_W)) mem_bus ();

    dmb_burst_mem #(
        .W  (DQ_W),
        .AW (COL_W)
    ) u_mem (
        .core_clk_i (core_clk_i),
        .port       (mem_bus.mem)
    );

    logic rd_drive;
    logic wr_slot;

    assign rd_drive = (state_reg == ST_RD_BURST) && (!chop_reg || beat_reg <= CHOP_LAST);
    assign wr_slot  = (state_reg == ST_WR_BURST) && ck_edge;

    assign mem_bus.rd_addr = {col_reg[COL_W-1:BEAT_W], beat_col(col_reg[2:0], beat_reg, il_reg)};
    assign mem_bus.wr_en   = wr_slot && (!chop_reg || beat_reg <= CHOP_LAST);
    assign mem_bus.wr_addr = chop_reg
        ? {col_reg[COL_W-1:BEAT_W], col_reg[2], beat_reg[1:0]}
        : {col_reg[COL_W-1:BEAT_W], beat_reg};
    assign mem_bus.wr_data = dq_s2;

    // Read drivers; strobe follows the sampled clock
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            dq_o       <= '0;
            dq_oe_n_o  <= 1'b1;
            dqs_o      <= 1'b0;
            dqs_oe_n_o <= 1'b1;
        end
        else
        begin
            dq_o       <= mem_bus.rd_data;
            dq_oe_n_o  <= ~rd_drive;
            dqs_o      <= ck_s2;
            dqs_oe_n_o <= ~rd_drive;
        end
    end

    // Internal write point: fixed chop commits two clocks early
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            wr_recov_start_o <= 1'b0;
        end
        else
        begin
            wr_recov_start_o <= wr_slot &&
                (beat_reg == (early_reg ? BEAT_LAST - 3'(2 * CHOP_EARLY_CK) : BEAT_LAST));
        end
    end

    // Status outputs
    logic wr_active;
    assign wr_active = (state_reg == ST_WR_BURST);

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            dll_active_o    <= 1'b0;
            dll_needed_o    <= 1'b0;
            fast_exit_o     <= 1'b0;
            test_mode_o     <= 1'b0;
            drive_imp_o     <= '0;
            rtt_nom_o       <= '0;
            term_on_o       <= 1'b0;
            read_latency_o  <= '0;
            autoclose_dly_o <= '0;
        end
        else
        begin
            // Self-refresh and slow-exit power-down stop the DLL
            dll_active_o    <= !mr1_reg[MR1_DLL_DIS] && !sr_reg
                               && !(pd_reg && !mr0_reg[MR0_PPD]);
            dll_needed_o    <= wr_active && (wt_s2 != 2'h0);
            fast_exit_o     <= mr0_reg[MR0_PPD];
            test_mode_o     <= mr0_reg[MR0_TEST];
            drive_imp_o     <= {mr1_reg[MR1_DRV_HI], mr1_reg[MR1_DRV_LO]};
            rtt_nom_o       <= {mr1_reg[MR1_RTT_B2], mr1_reg[MR1_RTT_B1], mr1_reg[MR1_RTT_B0]};
            term_on_o       <= odt_s2 && ((wr_active && wt_s2 != 2'h0) || rtt_nom_o != 3'h0);
            read_latency_o  <= rl_cyc;
            autoclose_dly_o <= wr_cycles(mr0_reg[MR0_WR_HI:MR0_WR_LO]) + PRECHG_CYC;
        end
    end

    // Checks
    // Self-clear window with margin for the load cycle
    localparam int DLL_BOUND = DLL_RST_CYC + 2;

    sequence s_mr0_cmd;
        mrs_cmd && ba == BA_MR0;
    endsequence

    sequence s_mr1_cmd;
        mrs_cmd && ba == BA_MR1;
    endsequence

    a_mr0_load: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_mr0_cmd |=> mr0_reg[7:0] == $past(addr[7:0]))
        else $error("mode register zero not loaded");
    a_mr1_load: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_mr1_cmd |=> mr1_reg == $past(addr))
        else $error("mode register one not loaded");
    a_dll_rst_clear: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(mr0_reg[MR0_DLL_RST]) |-> ##[1:DLL_BOUND] !mr0_reg[MR0_DLL_RST])
        else $error("dll reset bit did not clear");
    a_chop_float: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        state_reg == ST_RD_BURST && chop_reg && beat_reg > CHOP_LAST |=> dq_oe_n_o && dqs_oe_n_o)
        else $error("chopped read drove a dead slot");
    a_read_order: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        state_reg == ST_RD_BURST && !il_reg |-> mem_bus.rd_addr[1:0] == 2'(col_reg[1:0] + beat_reg[1:0]))
        else $error("sequential order wrong");
    a_dll_self_ref: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        sr_reg ##1 sr_reg |-> !dll_active_o)
        else $error("dll running in self-refresh");
    a_drive_imp: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_mr1_cmd |-> ##2 drive_imp_o == {$past(addr[5], 2), $past(addr[1], 2)})
        else $error("driver impedance not applied");
    a_chop_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        wr_slot && chop_reg && beat_reg > CHOP_LAST |-> !mem_bus.wr_en)
        else $error("chopped write touched array");
    a_rl_total: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        rd_cmd && state_reg == ST_IDLE |=> lat_reg == rl_cyc)
        else $error("read latency wrong");
endmodule : dmb_mode_burst

/* sim/dmb_ctrl_model.sv */
`timescale 1ns/1ps
module dmb_ctrl_model (
    // Core clock
    input  wire logic   core_clk_i,
    // Pins towards the device
    output logic        ck_o,
    output logic        cke_o,
    output logic [3:0]  cmd_n_o,
    output logic [2:0]  ba_o,
    output logic [15:0] addr_o,
    output logic [1:0]  wterm_o,
    output logic [7:0]  dq_o
);
    // Free running, offset so its edges never coincide with core clock edges
    initial
    begin
        ck_o = 1'b0;
        #3;
        forever #80 ck_o = ~ck_o;
    end
    initial
    begin
        cke_o   = 1'b1;
        cmd_n_o = 4'hf;
        ba_o    = 3'h0;
        addr_o  = 16'h0000;
        wterm_o = 2'h0;
        dq_o    = 8'h00;
    end
    // Pins change after a falling edge, so they are stable around the rise
    task automatic send(input logic [3:0] cmd, input logic [2:0] ba, input logic [15:0] a);
        @(negedge ck_o);
        @(posedge core_clk_i);
        cmd_n_o <= cmd;
        ba_o    <= ba;
        addr_o  <= a;
        @(negedge ck_o);
        @(posedge core_clk_i);
        cmd_n_o <= 4'hf;
        addr_o  <= ~a;
    endtask : send
    task automatic mode_reg_set_cmd(input logic [2:0] ba, input logic [15:0] v);
        send(4'h0, {1'b0, ba[1:0]}, ba[0] ? (v & 16'h1aff) : (v & 16'h1f7f));
    endtask : mode_reg_set_cmd
    task automatic rd(input logic [5:0] c, input logic a12);
        send(4'h5, 3'h0, {3'h0, a12, 6'h00, c});
    endtask : rd
    task automatic wr(input logic [5:0] c, input logic a12, input int wl,
                      input logic [63:0] d, input logic [1:0] wt);
        wterm_o <= wt;
        send(4'h4, 3'h0, {3'h0, a12, 6'h00, c});
        repeat (wl) @(posedge ck_o);
        // Beat i stands from ck edge i up to ck edge i+1; released bus shows the inverse
        for (int i = 0; i < 9; i++)
        begin
            if (i > 0)
                @(ck_o);
            repeat (2) @(posedge core_clk_i);
            dq_o <= (i < 8) ? d[8*i +: 8] : ~d[63:56];
        end
    endtask : wr
    task automatic pd(input logic v);
        @(negedge ck_o);
        @(posedge core_clk_i);
        cke_o <= v;
    endtask : pd
    // Refresh command with clock enable dropping enters self-refresh
    task automatic sref();
        @(negedge ck_o);
        @(posedge core_clk_i);
        cke_o   <= 1'b0;
        cmd_n_o <= 4'h1;
        @(negedge ck_o);
        @(posedge core_clk_i);
        cmd_n_o <= 4'hf;
    endtask : sref
endmodule : dmb_ctrl_model

/* sim/ddr3_mode_reg_burst_order_tb.sv */
`timescale 1ns/1ps
module ddr3_mode_reg_burst_order_tb;
    import dmb_pkg::*;
    localparam int CWL = 5;
    localparam int PRE = 6;
    logic        core_clk_i = 1'b0;
    logic        sys_rst_i  = 1'b1;
    logic        ck, cke, dq_oe_n, dqs, dqs_oe_n, dll_act, dll_need, fexit, tmode, term, wrs;
    logic [3:0]  cmd_n;
    logic [2:0]  ba, rtt;
    logic [15:0] addr;
    logic [1:0]  wterm, drv, bl;
    logic [7:0]  dq_wr, dq_rd;
    logic [5:0]  rl, acd;
    logic [7:0]  mem [64];
    logic [31:0] seed = 32'he29404bd;
    logic        bt, seen_term, seen_need;
    logic        die_termination = 1'b0;
    logic [2:0]  rtt_e;
    int          failures, num_checks, rl_exp, wl;
    longint      t_rec, ref_off = -1, d8, dl;
    dmb_ctrl_model ctl (.core_clk_i(core_clk_i), .ck_o(ck), .cke_o(cke), .cmd_n_o(cmd_n),
        .ba_o(ba), .addr_o(addr), .wterm_o(wterm), .dq_o(dq_wr));
    dmb_mode_burst #(.CWL_CYC(6'(CWL)), .PRECHG_CYC(6'(PRE))) dmb_mode_burst_inst (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ck_i(ck), .cke_i(cke),
        .chip_sel_n_i(cmd_n[3]), .row_strobe_n_i(cmd_n[2]), .column_strobe_n_i(cmd_n[1]),
        .write_en_n_i(cmd_n[0]), .bank_sel_i(ba), .addr_i(addr), .die_termination_i(die_termination),
        .wr_term_code_i(wterm), .dq_i(dq_wr), .dq_o(dq_rd), .dq_oe_n_o(dq_oe_n), .dqs_o(dqs),
        .dqs_oe_n_o(dqs_oe_n), .dll_active_o(dll_act), .dll_needed_o(dll_need),
        .fast_exit_o(fexit), .test_mode_o(tmode), .drive_imp_o(drv), .rtt_nom_o(rtt),
        .term_on_o(term), .read_latency_o(rl), .autoclose_dly_o(acd), .wr_recov_start_o(wrs));
    initial
    begin
        forever #10 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
    begin
        if (wrs === 1'b1)
            t_rec = $time;
        if (term === 1'b1)
            seen_term = 1'b1;
        if (dll_need === 1'b1)
            seen_need = 1'b1;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic int wrc(input logic [2:0] c);
        return (c == 3'h0) ? 16 : (c < 3'h5) ? c + 4 : 2 * c;
    endfunction : wrc
    function automatic logic [5:0] word(input logic [5:0] c, input int i, input logic il);
        logic [2:0] b;
        b = i[2:0];
        return il ? {c[5:3], c[2:0] ^ b} : {c[5:3], c[2] ^ b[2], c[1:0] + b[1:0]};
    endfunction : word
    task automatic tick();
        @(posedge core_clk_i);
        #1;
    endtask : tick
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task automatic prog(input logic [15:0] v0, input logic [15:0] v1);
        int cl;
        int al;
        ctl.mode_reg_set_cmd(3'h1, v1);
        ctl.mode_reg_set_cmd(3'h0, v0);
        repeat (6) tick();
        cl = 4 + {v0[2], v0[6:4]};
        al = (v1[4:3] == 2'h1) ? cl - 1 : (v1[4:3] == 2'h2) ? cl - 2 : 0;
        bl = v0[1:0];
        bt = v0[3];
        rtt_e = {v1[9], v1[6], v1[2]};
        rl_exp = al + cl;
        wl = al + CWL;
        chk(rl, 16'(rl_exp));
        chk(acd, 16'(wrc(v0[11:9]) + PRE));
        chk({drv, rtt}, {v1[5], v1[1], v1[9], v1[6], v1[2]});
        chk({fexit, tmode, dll_act}, {v0[12], 2'b01});
    endtask : prog
    task automatic dowr(input logic [5:0] c, input logic a12, input logic [1:0] wt,
                        output longint dlt);
        logic [63:0] d;
        logic        ch;
        longint      t0;
        d  = {rnd(), rnd()};
        ch = (bl == 2'h2) || (bl == 2'h1 && !a12);
        for (int i = 0; i < 8; i++)
            if (!ch)
                mem[{c[5:3], 3'(i)}] = d[8*i +: 8];
            else if (i < 4)
                mem[{c[5:3], c[2], 2'(i)}] = d[8*i +: 8];
        seen_term = 1'b0;
        seen_need = 1'b0;
        @(posedge core_clk_i);
        die_termination <= 1'b1;
        @(posedge ck);
        t0 = $time;
        ctl.wr(c, a12, wl, d, wt);
        repeat (12) @(posedge core_clk_i);
        die_termination <= 1'b0;
        dlt = t_rec - t0;
        chk(seen_term, wt != 2'h0 || rtt_e != 3'h0);
        chk(seen_need, wt != 2'h0);
    endtask : dowr
    task automatic dord(input logic [5:0] c, input logic a12);
        longint t0;
        logic   ch;
        ch = (bl == 2'h2) || (bl == 2'h1 && !a12);
        @(posedge ck);
        t0 = $time;
        ctl.rd(c, a12);
        for (int n = 0; n < 600 && dq_oe_n !== 1'b0; n++)
            tick();
        if (ref_off < 0)
            ref_off = $time - t0 - rl_exp * 160;
        chk(16'($time - t0 - rl_exp * 160), 16'(ref_off));
        tick();
        for (int i = 0; i < 8; i++)
        begin
            tick();
            if (ch && i > 3)
                chk({dq_oe_n, dqs_oe_n}, 2'b11);
            else
                chk({dqs_oe_n, dqs, dq_rd}, {1'b0, ~i[0], mem[word(c, i, bt)]});
            repeat (3) tick();
        end
    endtask : dord
    initial
    begin
        #400000;
        failures++;
        wrap_up();
    end
    initial
    begin
        logic [31:0] r;
        repeat (6) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) tick();
        ctl.mode_reg_set_cmd(3'h1, 16'h0000);
        ctl.mode_reg_set_cmd(3'h0, 16'h0100);
        repeat (20) @(posedge ck);
        prog(16'h0000, 16'h0000);
        for (int g = 0; g < 8; g++)
            dowr({g[2:0], 3'h0}, 1'b1, 2'h0, d8);
        prog(16'h0002, 16'h0000);
        dowr(6'h00, 1'b0, 2'h1, dl);
        chk(16'(dl), 16'(d8 - 320));
        prog(16'h0001, 16'h0000);
        dowr(6'h08, 1'b0, 2'h2, dl);
        chk(16'(dl), 16'(d8));
        $display("fill and recovery test done");
        for (int k = 0; k < 8; k++)
        begin
            r = rnd();
            // Write leveling off and no weak nominal values
            prog({3'h0, r[12:9], 3'h0, r[5:4], k[2], 1'b0, k[1:0]},
                 {7'h00, 2'h0, r[16], r[17], r[19:18], r[20], r[21], 1'b0});
            dowr(r[31:26], r[6], r[8:7], dl);
            r = rnd();
            dord(r[5:0], r[6]);
            $display("test %0d done", k);
        end
        for (int f = 0; f < 2; f++)
        begin
            prog({3'h0, f[0], 12'h000}, 16'h0000);
            ctl.pd(1'b0);
            repeat (4) @(posedge ck);
            chk(dll_act, f[0]);
            ctl.pd(1'b1);
            repeat (4) @(posedge ck);
            chk(dll_act, 1'b1);
        end
        ctl.sref();
        repeat (4) @(posedge ck);
        chk(dll_act, 1'b0);
        ctl.pd(1'b1);
        repeat (4) @(posedge ck);
        chk(dll_act, 1'b1);
        $display("power-down test done");
        wrap_up();
    end
endmodule : ddr3_mode_reg_burst_order_tb
